//--- gtc_pkg.sv
/*
  Package for the gated 16-bit timer/counter: register indices, field
  positions, reset values and clock source codes.
  Assumes a plain address/strobe register port with 8-bit data.
*/
package gtc_pkg;
  // ************************************************************
  // Register indices (byte wide registers)
  // ************************************************************
  localparam logic [3:0] ADDR_COUNT_LOW  = 4'h0;  // Low byte of live count
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;  // High byte of live count
  localparam logic [3:0] ADDR_CONTROL    = 4'h2;  // Timer control
  localparam logic [3:0] ADDR_CONFIG     = 4'h3;  // Gate source, alternate clock
  localparam logic [3:0] ADDR_FLAGS      = 4'h4;  // Overflow flag
  localparam logic [3:0] ADDR_IRQ_EN     = 4'h5;  // Interrupt enables
  localparam logic [3:0] ADDR_CAPTURE_LO = 4'h6;  // Capture/compare low byte
  localparam logic [3:0] ADDR_CAPTURE_HI = 4'h7;  // Capture/compare high byte
  localparam logic [3:0] ADDR_PIN_VIEW   = 4'h8;  // Shared pin direction/data view

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int CTL_TIMER_ON   = 0;
  localparam int CTL_SOURCE_SEL = 1;
  localparam int CTL_SYNC_DIS   = 2;
  localparam int CTL_OSC_EN     = 3;
  localparam int CTL_PRESCALE   = 4;  // Two bits, 5:4
  localparam int CTL_GATE_EN    = 6;
  localparam int CTL_GATE_INV   = 7;

  // Config register fields
  localparam int CFG_GATE_SRC   = 1;  // 1 selects the gate pin, 0 the comparator
  localparam int CFG_ALT_CLK    = 4;

  // Interrupt enable fields
  localparam int IEN_OVERFLOW   = 0;
  localparam int IEN_PERIPHERAL = 1;
  localparam int IEN_GLOBAL     = 2;

  // Pin view fields
  localparam int PIN_A_DIR = 0;
  localparam int PIN_B_DIR = 1;
  localparam int PIN_A_DAT = 2;
  localparam int PIN_B_DAT = 3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  CONFIG_RESET  = 8'h02;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [2:0]  PRESCALE_ZERO = 3'h0;

  // Instruction clock is the system clock divided by this
  localparam int INSTR_DIV = 4;

  // Clock source selection
  typedef enum logic [1:0] {
    GTC_SRC_INSTR,
    GTC_SRC_SYSTEM,
    GTC_SRC_EXTERNAL
  } gtc_src_t;
endpackage

//--- gtc_timer.sv
/*
  Gated 16-bit timer/counter with prescaler, gate, capture/compare
  time base and special event clear.
  Assumes one clock sys_clk at 200 MHz, synchronous active high reset,
  and pins that arrive asynchronously to sys_clk.
*/
// Our own choices: the strobed register port and the placing of the registers.
// Behaviour
// - 16-bit counter, byte writes load live count
// - Source: instruction, system, or external pin
// - External counts rising edges after falling edge
// - Prescale selected clock by 1,2,4,8
// - Prescaler hidden, cleared on count writes
// - Oscillator enable starts crystal, runs asleep
// - Oscillator allowed only with suitable primary clock
// - Oscillator on: pin directions one, data zero
// - Sync disable only keeps external counting alive asleep
// - Asynchronous counting runs asleep, overflow wakes
// - Byte reads valid; software handles split overflow
// - Gate from pin or comparator when enabled
// - Gate invert flips polarity for both sources
// - Rollover to zero sets overflow flag
// - Overflow in sleep wakes; vector if global
// - Capture copies count; compare fires on equality
// - Special event clears count without flag
// - Count write beats special event clear
// - Gate enabled: count only when gate allows
// - Invert set counts gate high, else low
`timescale 1ns/1ps
`default_nettype none
module gtc_timer (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       external_count_pin,
  input  wire logic       crystal_clk_pin,
  input  wire logic       gate_pin,
  input  wire logic       second_comparator_output,
  input  wire logic       primary_clk_ok,
  input  wire logic       core_sleeping,
  input  wire logic       capture_event,
  input  wire logic       special_event_enable,
  output logic            compare_match,
  output logic            crystal_osc_running,
  output logic            overflow_irq,
  output logic            wake_request,
  output logic            wake_vector
);
  // ************************************************************
  // Register bank
  // ************************************************************
  logic [15:0] count_ff;             // Live count
  logic [7:0]  control_ff;           // Timer control
  logic [7:0]  config_ff;            // Gate source and alternate clock
  logic        overflow_flag_ff;     // Sticky rollover flag
  logic [2:0]  irq_en_ff;            // Overflow, peripheral, global enables
  logic [15:0] compare_ff;           // Capture/compare pair
  logic [2:0]  prescale_ff;          // Hidden prescale counter
  logic [1:0]  instr_div_ff;         // Instruction clock divider
  logic [7:0]  rdata_ff;             // Read data, one cycle late
  logic        seen_fall_ff;         // Falling edge seen on count input
  logic [2:0]  ext_sync_ff;          // External input synchroniser
  logic [2:0]  gate_sync_ff;         // Gate pin synchroniser
  logic [2:0]  cmp_sync_ff;          // Comparator synchroniser
  logic        ext_level_ff;         // Agreed external level
  logic        gate_level_ff;        // Agreed gate pin level
  logic        cmp_level_ff;         // Agreed comparator level
  logic        src_prev_ff;          // Last agreed external level
  logic        match_prev_ff;        // Last compare equality

  // ************************************************************
  // Decoding
  // ************************************************************
  wire wr_low   = reg_write && (reg_addr == gtc_pkg::ADDR_COUNT_LOW);
  wire wr_high  = reg_write && (reg_addr == gtc_pkg::ADDR_COUNT_HIGH);
  wire wr_count = wr_low || wr_high;
  wire wr_ctl   = reg_write && (reg_addr == gtc_pkg::ADDR_CONTROL);
  wire wr_cfg   = reg_write && (reg_addr == gtc_pkg::ADDR_CONFIG);
  wire wr_flag  = reg_write && (reg_addr == gtc_pkg::ADDR_FLAGS);
  wire wr_ien   = reg_write && (reg_addr == gtc_pkg::ADDR_IRQ_EN);
  wire wr_cmp_l = reg_write && (reg_addr == gtc_pkg::ADDR_CAPTURE_LO);
  wire wr_cmp_h = reg_write && (reg_addr == gtc_pkg::ADDR_CAPTURE_HI);

  wire       timer_on     = control_ff[gtc_pkg::CTL_TIMER_ON];
  wire       source_sel   = control_ff[gtc_pkg::CTL_SOURCE_SEL];
  wire       sync_disable = control_ff[gtc_pkg::CTL_SYNC_DIS];
  wire       gate_enable  = control_ff[gtc_pkg::CTL_GATE_EN];
  wire       gate_invert  = control_ff[gtc_pkg::CTL_GATE_INV];
  wire [1:0] prescale_sel = control_ff[gtc_pkg::CTL_PRESCALE +: 2];
  wire       alt_clk_sel  = config_ff[gtc_pkg::CFG_ALT_CLK];
  wire       gate_src_pin = config_ff[gtc_pkg::CFG_GATE_SRC];

  // Enable is ignored unless the primary clock leaves the crystal free
  wire osc_on = control_ff[gtc_pkg::CTL_OSC_EN] && primary_clk_ok;

  // Clock source selection
  gtc_pkg::gtc_src_t src;
  assign src = source_sel  ? gtc_pkg::GTC_SRC_EXTERNAL :
               alt_clk_sel ? gtc_pkg::GTC_SRC_SYSTEM : gtc_pkg::GTC_SRC_INSTR;

  // External input is the crystal when the oscillator runs
  wire ext_raw = osc_on ? crystal_clk_pin : external_count_pin;

  // Gate: source select, inversion, enable
  wire gate_raw   = gate_src_pin ? gate_level_ff : cmp_level_ff;
  wire gate_allow = gate_invert ? gate_raw : !gate_raw;
  wire run        = timer_on && (!gate_enable || gate_allow);

  // External rising edge, counted only after a falling edge
  wire ext_rise = ext_level_ff && !src_prev_ff && seen_fall_ff;
  wire ext_fall = !ext_level_ff && src_prev_ff;

  // Raw tick of the selected clock before prescaling
  logic src_tick;
  always_comb begin
    unique case (src)
      gtc_pkg::GTC_SRC_INSTR:    src_tick = (instr_div_ff == 2'(gtc_pkg::INSTR_DIV - 1));
      gtc_pkg::GTC_SRC_SYSTEM:   src_tick = 1'b1;
      gtc_pkg::GTC_SRC_EXTERNAL: src_tick = ext_rise;
      default:                   src_tick = 1'b0;
    endcase
  end

  // Prescale terminal: wraps at 1, 2, 4 or 8 ticks
  function automatic logic presc_done(input logic [2:0] cnt, input logic [1:0] sel);
    logic [2:0] lim;
    lim = 3'((4'h1 << sel) - 4'h1);
    presc_done = (cnt == lim);
  endfunction

  wire tick    = run && src_tick;
  wire inc     = tick && presc_done(prescale_ff, prescale_sel);

  // Compare event, one pulse per fresh equality
  wire match_now  = (compare_ff == count_ff);
  wire match_edge = match_now && !match_prev_ff;
  wire special_clear = match_edge && special_event_enable;

  // A count write or a period clear replaces the increment, so no roll
  // happens then and the flag stays as it was
  wire rollover = inc && (count_ff == gtc_pkg::COUNT_MAX)
                  && !wr_count && !special_clear;

  // ************************************************************
  // Next count
  // ************************************************************
  logic [15:0] nxt_count;
  always_comb begin
    if (wr_low) begin
      nxt_count = {count_ff[15:8], reg_wdata};
    end else if (wr_high) begin
      nxt_count = {reg_wdata, count_ff[7:0]};
    end else if (special_clear) begin
      nxt_count = gtc_pkg::COUNT_RESET;
    end else if (inc) begin
      nxt_count = count_ff + 16'h0001;
    end else begin
      nxt_count = count_ff;
    end
  end

  // ************************************************************
  // Synchronisers for pins
  // ************************************************************
  // Three flops; a level is taken once the last two agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ext_sync_ff   <= 3'h0;
      gate_sync_ff  <= 3'h0;
      cmp_sync_ff   <= 3'h0;
      ext_level_ff  <= 1'b0;
      gate_level_ff <= 1'b0;
      cmp_level_ff  <= 1'b0;
    end else begin
      ext_sync_ff   <= {ext_sync_ff[1:0], ext_raw};
      gate_sync_ff  <= {gate_sync_ff[1:0], gate_pin};
      cmp_sync_ff   <= {cmp_sync_ff[1:0], second_comparator_output};
      if (ext_sync_ff[2] == ext_sync_ff[1]) begin
        ext_level_ff <= ext_sync_ff[1];
      end
      if (gate_sync_ff[2] == gate_sync_ff[1]) begin
        gate_level_ff <= gate_sync_ff[1];
      end
      if (cmp_sync_ff[2] == cmp_sync_ff[1]) begin
        cmp_level_ff <= cmp_sync_ff[1];
      end
    end
  end

  // ************************************************************
  // Edge tracking and dividers
  // ************************************************************
  // Unsynchronised mode still samples the pin here: one clock domain only,
  // so sync_disable changes only whether sleep keeps the count alive
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      src_prev_ff   <= 1'b0;
      seen_fall_ff  <= 1'b0;
      instr_div_ff  <= 2'h0;
      match_prev_ff <= 1'b0;
    end else begin
      src_prev_ff   <= ext_level_ff;
      instr_div_ff  <= instr_div_ff + 2'h1;
      match_prev_ff <= match_now;
      if (!source_sel || !timer_on) begin
        seen_fall_ff <= 1'b0;   // Re-arm when counting is off
      end else if (ext_fall) begin
        seen_fall_ff <= 1'b1;
      end
    end
  end

  // Prescaler: cleared on any count byte write
  always_ff @(posedge sys_clk) begin
    if (sys_rst || wr_count) begin
      prescale_ff <= gtc_pkg::PRESCALE_ZERO;
    end else if (tick) begin
      prescale_ff <= presc_done(prescale_ff, prescale_sel) ? gtc_pkg::PRESCALE_ZERO
                                                            : prescale_ff + 3'h1;
    end
  end

  // ************************************************************
  // Count, flag and registers
  // ************************************************************
  // In sleep only the asynchronous external mode keeps counting
  wire sleep_freeze = core_sleeping && !(source_sel && sync_disable);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_ff <= gtc_pkg::COUNT_RESET;
    end else if (!sleep_freeze || wr_count) begin
      count_ff <= nxt_count;
    end
  end

  // Overflow flag: set wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      overflow_flag_ff <= 1'b0;
    end else if (rollover && !sleep_freeze) begin
      overflow_flag_ff <= 1'b1;
    end else if (wr_flag) begin
      overflow_flag_ff <= reg_wdata[0];
    end
  end

  // Software registers and capture
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      control_ff <= gtc_pkg::CONTROL_RESET;
      config_ff  <= gtc_pkg::CONFIG_RESET;
      irq_en_ff  <= 3'h0;
      compare_ff <= gtc_pkg::COUNT_RESET;
    end else begin
      if (wr_ctl) control_ff <= reg_wdata;
      if (wr_cfg) config_ff  <= reg_wdata;
      if (wr_ien) irq_en_ff  <= reg_wdata[2:0];
      if (capture_event) begin
        compare_ff <= count_ff;
      end else begin
        if (wr_cmp_l) compare_ff[7:0]  <= reg_wdata;
        if (wr_cmp_h) compare_ff[15:8] <= reg_wdata;
      end
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  // Pin view forced while the crystal runs
  wire [7:0] pin_view = osc_on ? 8'h03 : 8'h00;

  logic [7:0] nxt_rdata;
  always_comb begin
    unique case (reg_addr)
      gtc_pkg::ADDR_COUNT_LOW:  nxt_rdata = count_ff[7:0];
      gtc_pkg::ADDR_COUNT_HIGH: nxt_rdata = count_ff[15:8];
      gtc_pkg::ADDR_CONTROL:    nxt_rdata = control_ff;
      gtc_pkg::ADDR_CONFIG:     nxt_rdata = config_ff;
      gtc_pkg::ADDR_FLAGS:      nxt_rdata = {7'h00, overflow_flag_ff};
      gtc_pkg::ADDR_IRQ_EN:     nxt_rdata = {5'h00, irq_en_ff};
      gtc_pkg::ADDR_CAPTURE_LO: nxt_rdata = compare_ff[7:0];
      gtc_pkg::ADDR_CAPTURE_HI: nxt_rdata = compare_ff[15:8];
      gtc_pkg::ADDR_PIN_VIEW:   nxt_rdata = pin_view;
      default:                  nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_read ? nxt_rdata : 8'h00;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  wire irq_path = overflow_flag_ff && irq_en_ff[gtc_pkg::IEN_OVERFLOW]
                  && irq_en_ff[gtc_pkg::IEN_PERIPHERAL];
  assign reg_rdata           = rdata_ff;
  assign compare_match       = match_edge;
  assign crystal_osc_running = osc_on;
  assign overflow_irq        = irq_path && irq_en_ff[gtc_pkg::IEN_GLOBAL];
  assign wake_request        = irq_path && timer_on && core_sleeping;
  assign wake_vector         = wake_request && irq_en_ff[gtc_pkg::IEN_GLOBAL];
endmodule
`default_nettype wire

//--- gtc_props.sv
/*
  Checker for the gated timer: register port timing, oscillator
  outputs, compare pulse and wake outputs.
  Assumes it is bound onto gtc_timer and gtc_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module gtc_props (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       primary_clk_ok,
  input wire logic       core_sleeping,
  input wire logic       compare_match,
  input wire logic       crystal_osc_running,
  input wire logic       overflow_irq,
  input wire logic       wake_request,
  input wire logic       wake_vector
);
  // ************************************************************
  // One clock domain; reset masks every check
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  rdata_idle_a:
    assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data standing outside the answer cycle");
  unmapped_read_a:
    assert property (reg_read && reg_addr > 4'h8 |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  ctl_readback_a:
    assert property (reg_write && reg_addr == gtc_pkg::ADDR_CONTROL ##1 reg_read &&
      reg_addr == gtc_pkg::ADDR_CONTROL |=> reg_rdata == $past(reg_wdata, 2))
    else $error("control byte did not read back");
  osc_start_a:
    assert property (reg_write && reg_addr == gtc_pkg::ADDR_CONTROL &&
      reg_wdata[gtc_pkg::CTL_OSC_EN] ##1 primary_clk_ok |-> crystal_osc_running)
    else $error("crystal did not start");
  osc_gate_a:
    assert property (!primary_clk_ok |-> !crystal_osc_running)
    else $error("crystal running without suitable primary clock");
  pin_view_a:
    assert property (reg_read && reg_addr == gtc_pkg::ADDR_PIN_VIEW &&
      crystal_osc_running |=> reg_rdata[3:0] == 4'h3)
    else $error("shared pin view wrong while crystal on");
  match_pulse_a:
    assert property (compare_match |=> !compare_match)
    else $error("compare match longer than one cycle");
  wake_vector_a:
    assert property (wake_vector |-> overflow_irq && wake_request)
    else $error("vector without interrupt and wake");
  flag_bits_a:
    assert property (reg_read && reg_addr == gtc_pkg::ADDR_FLAGS |=> reg_rdata[7:1] == 7'h00)
    else $error("flag register shows stray bits");
  wake_sleep_a:
    assert property ($rose(wake_request) |-> core_sleeping)
    else $error("wake raised while awake");
endmodule
bind gtc_timer gtc_props gtc_props_i (
  .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .primary_clk_ok, .core_sleeping, .compare_match, .crystal_osc_running,
  .overflow_irq, .wake_request, .wake_vector
);
`default_nettype wire

//--- gtc_partner.sv
/*
  Far-side model: bursts on the external count pin and a crystal.
  Assumes burst is called right after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module gtc_partner (
  input  wire logic sys_clk,
  input  wire logic xtal_run,
  output var  logic ext_pin,
  output var  logic xtal_pin
);
  // ************************************************************
  // Count pin idles low, so a burst opens with a rising edge
  // that has no falling edge before it
  // ************************************************************
  initial ext_pin = 1'b0;
  task automatic burst(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge sys_clk);
      ext_pin <= 1'b1;
      repeat (half) @(posedge sys_clk);
      ext_pin <= 1'b0;
    end
  endtask
  // Crystal toggles only while enabled, still otherwise
  initial xtal_pin = 1'b0;
  always #15.25 xtal_pin = xtal_run ? ~xtal_pin : 1'b0;
endmodule
`default_nettype wire

//--- gtc_tb.sv
/*
  Self-checking bench: reset values, prescale, loads, capture,
  overflow, wake, period clear, gate, external count, crystal.
  Assumes gtc_pkg, gtc_timer, gtc_partner and gtc_props compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  logic        sys_clk, sys_rst, reg_write, reg_read, xtal_run, gate_pin;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, d;
  wire  [7:0]  reg_rdata;
  wire         external_count_pin, crystal_clk_pin, compare_match, crystal_osc_running;
  wire         overflow_irq, wake_request, wake_vector;
  logic        second_comparator_output, primary_clk_ok, core_sleeping;
  logic        capture_event, special_event_enable;
  logic        ext_ok;
  logic [15:0] seed, got;
  int          err_count, tests_run, i;

  gtc_timer gtc_timer_i (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .external_count_pin, .crystal_clk_pin, .gate_pin,
    .second_comparator_output, .primary_clk_ok, .core_sleeping, .capture_event,
    .special_event_enable, .compare_match, .crystal_osc_running, .overflow_irq,
    .wake_request, .wake_vector);
  gtc_partner gtc_partner_i (.sys_clk, .xtal_run, .ext_pin(external_count_pin),
    .xtal_pin(crystal_clk_pin));

  // ************************************************************
  // Bus tasks: strobes change just after an edge, one cycle long
  // ************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] dv);
    #1;
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= dv;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] dv);
    #1;
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 dv = reg_rdata;
  endtask
  // Byte pairs: low at a, high at a+1; not atomic, so timer stopped
  task automatic rdp(input logic [3:0] a, output logic [15:0] c);
    logic [7:0] l, h;
    rd(a, l);
    rd(a + 4'h1, h);
    c = {h, l};
  endtask
  task automatic ldp(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask
  // Counts are written only with the timer stopped
  task automatic run(input logic [7:0] ctl, input int n);
    wr(gtc_pkg::ADDR_CONTROL, ctl);
    repeat (n) @(posedge sys_clk);
    wr(gtc_pkg::ADDR_CONTROL, ctl & 8'hFE);
  endtask

  // ************************************************************
  // Expectations and stimulus source
  // ************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] ticks(input int n, input int div);
    return 16'(n / div);
  endfunction
  // Start and stop latency leave a small slack on run lengths
  function automatic logic near(input logic [15:0] g, input logic [15:0] e);
    return (g + 16'h0002 >= e) && (g <= e + 16'h0001);
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Whole run is under two thousand cycles; this cuts a hang short
  initial begin
    #100000;
    err_count++;
    test_done();
  end

  initial begin
    {sys_rst, reg_write, reg_read, reg_addr, reg_wdata} = {3'b100, 12'h000};
    {xtal_run, gate_pin, second_comparator_output, primary_clk_ok} = 4'h0;
    {core_sleeping, capture_event, special_event_enable} = 3'b000;
    {err_count, tests_run, seed} = {32'h0, 32'h0, 16'h8246};
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(gtc_pkg::ADDR_CONTROL, d);
    `CHK("control reset", gtc_pkg::CONTROL_RESET, d)
    rd(gtc_pkg::ADDR_CONFIG, d);
    `CHK("config reset", gtc_pkg::CONFIG_RESET, d)
    wr(gtc_pkg::ADDR_CONTROL, 8'h30);
    rd(gtc_pkg::ADDR_CONTROL, d);
    `CHK("control", 8'h30, d)
    // Both internal sources and every prescale: system when alternate bit set
    for (i = 0; i < 8; i++) begin
      wr(gtc_pkg::ADDR_CONFIG, i[2] ? 8'h02 : 8'h12);
      ldp(gtc_pkg::ADDR_COUNT_LOW, 16'h0000);
      run({2'b00, i[1:0], 4'h1}, 96);
      rdp(gtc_pkg::ADDR_COUNT_LOW, got);
      `CHK("ticks", 1'b1, near(got, ticks(96, (i[2] ? 4 : 1) << i[1:0])))
    end
    // Random loads, capture copies, unmapped reads
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      ldp(gtc_pkg::ADDR_COUNT_LOW, seed);
      rdp(gtc_pkg::ADDR_COUNT_LOW, got);
      `CHK("load", seed, got)
      @(posedge sys_clk) capture_event <= 1'b1;
      @(posedge sys_clk) capture_event <= 1'b0;
      rdp(gtc_pkg::ADDR_CAPTURE_LO, got);
      `CHK("capture", seed, got)
      rd(4'hA + {2'b00, seed[1:0]}, d);
      `CHK("unmapped", 8'h00, d)
    end
    // Rollover, interrupt and wake from sleep
    wr(gtc_pkg::ADDR_CONFIG, 8'h12);
    ldp(gtc_pkg::ADDR_COUNT_LOW, 16'hFFFE);
    run(8'h01, 6);
    rd(gtc_pkg::ADDR_FLAGS, d);
    `CHK("overflow flag", 1'b1, d[0])
    wr(gtc_pkg::ADDR_IRQ_EN, 8'h07);
    wr(gtc_pkg::ADDR_CONTROL, 8'h07);
    core_sleeping <= 1'b1;
    @(posedge sys_clk) #1;
    `CHK("irq", 1'b1, overflow_irq)
    `CHK("wake", 1'b1, wake_request)
    `CHK("vector", 1'b1, wake_vector)
    wr(gtc_pkg::ADDR_IRQ_EN, 8'h03);
    #1 `CHK("no vector", 1'b0, wake_vector)
    wr(gtc_pkg::ADDR_CONTROL, 8'h00);
    core_sleeping <= 1'b0;
    wr(gtc_pkg::ADDR_FLAGS, 8'h00); // Service routine clears the flag
    rd(gtc_pkg::ADDR_FLAGS, d);
    `CHK("flag clear", 1'b0, d[0])
    // Compare pair acts as period: clears without a flag
    ldp(gtc_pkg::ADDR_CAPTURE_LO, 16'h0010);
    ldp(gtc_pkg::ADDR_COUNT_LOW, 16'h0000);
    special_event_enable <= 1'b1;
    run(8'h01, 100); // Synchronous source with the trigger
    special_event_enable <= 1'b0;
    rdp(gtc_pkg::ADDR_COUNT_LOW, got);
    `CHK("period", 1'b1, got <= 16'h0010)
    rd(gtc_pkg::ADDR_FLAGS, d);
    `CHK("period flag", 1'b0, d[0])
    // High byte write lands in the very cycle of a period clear
    ldp(gtc_pkg::ADDR_CAPTURE_LO, 16'h1234);
    ldp(gtc_pkg::ADDR_COUNT_LOW, 16'h1200);
    special_event_enable <= 1'b1;
    ldp(gtc_pkg::ADDR_COUNT_LOW, 16'h1234);
    special_event_enable <= 1'b0;
    rdp(gtc_pkg::ADDR_COUNT_LOW, got);
    `CHK("write wins", 16'h1234, got)
    // Gate: both sources, both polarities, both levels
    for (i = 0; i < 8; i++) begin
      @(posedge sys_clk) gate_pin <= i[0];
      second_comparator_output <= !i[0];
      repeat (8) @(posedge sys_clk);
      wr(gtc_pkg::ADDR_CONFIG, i[2] ? 8'h12 : 8'h10);
      ldp(gtc_pkg::ADDR_COUNT_LOW, 16'h0000);
      run({i[1], 1'b1, 5'h00, 1'b1}, 20);
      rdp(gtc_pkg::ADDR_COUNT_LOW, got);
      `CHK("gate", 1'((i[2] ? i[0] : !i[0]) == i[1]), got != 0)
    end
    // External pin: first rising edge has no falling edge before it;
    // asleep, only the unsynchronised mode keeps counting
    for (i = 0; i < 3; i++) begin
      ldp(gtc_pkg::ADDR_COUNT_LOW, 16'h0000);
      wr(gtc_pkg::ADDR_CONTROL, i[0] ? 8'h07 : 8'h03);
      core_sleeping <= (i != 0);
      gtc_partner_i.burst(5, 6);
      repeat (10) @(posedge sys_clk);
      wr(gtc_pkg::ADDR_CONTROL, 8'h00);
      core_sleeping <= 1'b0;
      rdp(gtc_pkg::ADDR_COUNT_LOW, got);
      ext_ok = (i == 2) ? (got == 16'h0000) : (got == 16'h0004 || (i[0] && got == 16'h0005));
      `CHK("external", 1'b1, ext_ok)
    end
    // Crystal only with a suitable primary clock; pin view follows
    for (i = 0; i < 2; i++) begin
      @(posedge sys_clk) primary_clk_ok <= i[0];
      xtal_run <= 1'b1;
      wr(gtc_pkg::ADDR_CONTROL, 8'h08);
      #1 `CHK("osc", i[0], crystal_osc_running)
      rd(gtc_pkg::ADDR_PIN_VIEW, d);
      `CHK("pins", i[0] ? 8'h03 : 8'h00, d)
    end
    repeat (20) @(posedge sys_clk); // settle before starting
    run(8'h09, 10);
    test_done();
  end
endmodule
`default_nettype wire
